// ---- hw/swau_top.sv ----
// Instruction datapath: table invert transfer and saturating word arithmetic
// How it works
// - Invert each of n source words into destination
// - Overlapping tables still give correct results
// - Add two signed words into destination
// - Overflow stores 32767 and drives output on
// - Underflow stores -32768 and drives output on
// - In-range add or subtract keeps output off
// - Subtract second operand from first into destination
// - Multiply to double word, output on
// - Upper product half goes to next word
// - Quotient to destination, remainder to next word
// - Zero divisor: no write, output off, error
// - Error flag sticks until program clears it
// - -32768 divided by -1 gives -32768, 0
`timescale 1ns/10ps
module swau_top
  import swau_pkg::*;
#(
  parameter int DEPTH = TBL_MAX
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              en_inv,
  input  wire logic              en_add,
  input  wire logic              en_sub,
  input  wire logic              en_mul,
  input  wire logic              en_div,
  input  wire logic [15:0]       opnd_a,
  input  wire logic [15:0]       opnd_b,
  input  wire logic [ADDR_W-1:0] src_addr,
  input  wire logic [ADDR_W-1:0] dst_addr,
  input  wire logic [LEN_W-1:0]  tbl_len,
  input  wire logic              err_clr,
  input  wire logic [15:0]       rd_data,
  output logic                   rd_en,
  output logic      [ADDR_W-1:0] rd_addr,
  output logic                   wr_en,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [15:0]       wr_data,
  output logic                   op_out,
  output logic                   instruction_error_flag
);
  typedef struct packed {
    swau_state_t       state;
    swau_op_t          op;
    logic [15:0]       a;
    logic [15:0]       b;
    logic [ADDR_W-1:0] src;
    logic [ADDR_W-1:0] dst;
    logic [LEN_W-1:0]  len;
    logic [LEN_W-1:0]  idx;
    logic [LEN_W-1:0]  cap;
    logic              pend;
    logic [15:0]       hi;
    logic              rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [15:0]       wr_data;
    logic              op_out;
    logic              err;
  } swau_regs_t;

  // Staging buffer index; a length above DEPTH would wrap it, so callers keep n <= DEPTH
  localparam int IDX_W = $clog2(DEPTH);

  swau_regs_t  st_r;
  swau_regs_t  st_nxt;
  logic [15:0] tbl_mem [DEPTH];
  logic [15:0] res_lo;
  logic [15:0] res_hi;
  logic        sat_hit;
  logic        div_zero;
  logic        any_en;

  // Arithmetic on the operands latched at start
  swau_calc u_calc (
    .op       (st_r.op),
    .opa      (st_r.a),
    .opb      (st_r.b),
    .res_lo   (res_lo),
    .res_hi   (res_hi),
    .sat_hit  (sat_hit),
    .div_zero (div_zero)
  );

  assign any_en = en_inv | en_add | en_sub | en_mul | en_div;

  // Whole source table is staged here before any write, so overlap is harmless
  always_ff @(posedge sys_clk) begin
    if (st_r.state == SWAU_TBL_RD && st_r.pend) begin
      tbl_mem[st_r.cap[IDX_W-1:0]] <= rd_data;
    end
  end

  // Sequencer and result path
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rd_en = 1'b0;
    st_nxt.wr_en = 1'b0;
    st_nxt.pend  = st_r.rd_en;
    case (st_r.state)
      SWAU_IDLE: begin
        st_nxt.op_out = 1'b0;
        st_nxt.a      = opnd_a;
        st_nxt.b      = opnd_b;
        st_nxt.src    = src_addr;
        st_nxt.dst    = dst_addr;
        st_nxt.len    = tbl_len;
        st_nxt.idx    = LEN_ZERO;
        st_nxt.cap    = LEN_ZERO;
        if (en_inv) begin
          st_nxt.op    = SWAU_OP_INV;
          st_nxt.state = SWAU_TBL_RD;
        end else if (en_add) begin
          st_nxt.op    = SWAU_OP_ADD;
          st_nxt.state = SWAU_CALC;
        end else if (en_sub) begin
          st_nxt.op    = SWAU_OP_SUB;
          st_nxt.state = SWAU_CALC;
        end else if (en_mul) begin
          st_nxt.op    = SWAU_OP_MUL;
          st_nxt.state = SWAU_CALC;
        end else if (en_div) begin
          st_nxt.op    = SWAU_OP_DIV;
          st_nxt.state = SWAU_CALC;
        end
      end
      SWAU_TBL_RD: begin
        if (st_r.idx < st_r.len) begin
          st_nxt.rd_en   = 1'b1;
          st_nxt.rd_addr = st_r.src + ADDR_W'(st_r.idx);
          st_nxt.idx     = st_r.idx + LEN_ONE;
        end
        if (st_r.pend) begin
          st_nxt.cap = st_r.cap + LEN_ONE;
          if (st_r.cap + LEN_ONE == st_r.len) begin
            st_nxt.idx   = LEN_ZERO;
            st_nxt.state = SWAU_TBL_WR;
          end
        end
      end
      SWAU_TBL_WR: begin
        st_nxt.wr_en   = 1'b1;
        st_nxt.wr_addr = st_r.dst + ADDR_W'(st_r.idx);
        st_nxt.wr_data = ~tbl_mem[st_r.idx[IDX_W-1:0]];
        st_nxt.idx     = st_r.idx + LEN_ONE;
        if (st_r.idx + LEN_ONE == st_r.len) begin
          st_nxt.op_out = 1'b1;
          st_nxt.state  = SWAU_DONE;
        end
      end
      SWAU_CALC: begin
        st_nxt.hi = res_hi;
        if (st_r.op == SWAU_OP_DIV && div_zero) begin
          st_nxt.op_out = 1'b0;
          st_nxt.state  = SWAU_DONE;
        end else begin
          st_nxt.wr_en   = 1'b1;
          st_nxt.wr_addr = st_r.dst;
          st_nxt.wr_data = res_lo;
          if (st_r.op == SWAU_OP_MUL || st_r.op == SWAU_OP_DIV) begin
            st_nxt.state = SWAU_WR_HI;
          end else begin
            st_nxt.op_out = sat_hit;
            st_nxt.state  = SWAU_DONE;
          end
        end
      end
      SWAU_WR_HI: begin
        st_nxt.wr_en   = 1'b1;
        st_nxt.wr_addr = st_r.dst + ADDR_ONE;
        st_nxt.wr_data = st_r.hi;
        st_nxt.op_out  = 1'b1;
        st_nxt.state   = SWAU_DONE;
      end
      SWAU_DONE: begin
        if (!any_en) begin
          st_nxt.op_out = 1'b0;
          st_nxt.state  = SWAU_IDLE;
        end
      end
      default: begin
        st_nxt.state = SWAU_IDLE;
      end
    endcase
    // Sticky error: a new zero divide wins over a clear in the same cycle
    if (st_r.state == SWAU_CALC && st_r.op == SWAU_OP_DIV && div_zero) begin
      st_nxt.err = 1'b1;
    end else if (err_clr) begin
      st_nxt.err = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_en                  = st_r.rd_en;
  assign rd_addr                = st_r.rd_addr;
  assign wr_en                  = st_r.wr_en;
  assign wr_addr                = st_r.wr_addr;
  assign wr_data                = st_r.wr_data;
  assign op_out                 = st_r.op_out;
  assign instruction_error_flag = st_r.err;
endmodule : swau_top

// ---- include/swau_pkg.sv ----
// Shared constants and types of the saturating word arithmetic unit
package swau_pkg;
  localparam int                WORD_W     = 16;
  localparam int                ADDR_W     = 16;
  localparam int                TBL_MAX    = 1024;
  localparam int                LEN_W      = 11;
  localparam logic [15:0]       SAT_POS    = 16'h7fff;
  localparam logic [15:0]       SAT_NEG    = 16'h8000;
  localparam logic [15:0]       WORD_ZERO  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 16'h0001;
  localparam logic [LEN_W-1:0]  LEN_ZERO   = 11'h000;
  localparam logic [LEN_W-1:0]  LEN_ONE    = 11'h001;

  // Operation selected for the running instruction
  typedef enum logic [2:0] {
    SWAU_OP_INV,
    SWAU_OP_ADD,
    SWAU_OP_SUB,
    SWAU_OP_MUL,
    SWAU_OP_DIV
  } swau_op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    SWAU_IDLE,
    SWAU_TBL_RD,
    SWAU_TBL_WR,
    SWAU_CALC,
    SWAU_WR_HI,
    SWAU_DONE
  } swau_state_t;
endpackage : swau_pkg

// ---- hw/swau_calc.sv ----
// Combinational add, subtract, multiply and divide on 16-bit signed words
`timescale 1ns/10ps
module swau_calc
  import swau_pkg::*;
(
  input  wire swau_op_t      op,
  input  wire logic [15:0]   opa,
  input  wire logic [15:0]   opb,
  output logic      [15:0]   res_lo,
  output logic      [15:0]   res_hi,
  output logic               sat_hit,
  output logic               div_zero
);
  logic signed [16:0] sum_w;
  logic signed [16:0] ext_a;
  logic signed [16:0] ext_b;
  logic signed [16:0] quo_w;
  logic signed [16:0] rem_w;
  logic signed [31:0] prod_w;

  // Widened arithmetic so that no result wraps before it is judged
  always_comb begin
    ext_a    = {opa[15], opa};
    ext_b    = {opb[15], opb};
    sum_w    = (op == SWAU_OP_SUB) ? (ext_a - ext_b) : (ext_a + ext_b);
    prod_w   = $signed(opa) * $signed(opb);
    div_zero = (opb == WORD_ZERO);
    quo_w    = div_zero ? 17'sh00000 : ext_a / ext_b;
    rem_w    = div_zero ? 17'sh00000 : ext_a % ext_b;
    res_lo   = WORD_ZERO;
    res_hi   = WORD_ZERO;
    sat_hit  = 1'b0;
    case (op)
      SWAU_OP_ADD, SWAU_OP_SUB: begin
        if (sum_w > $signed({1'b0, SAT_POS})) begin
          res_lo  = SAT_POS;
          sat_hit = 1'b1;
        end else if (sum_w < $signed({1'b1, SAT_NEG})) begin
          res_lo  = SAT_NEG;
          sat_hit = 1'b1;
        end else begin
          res_lo  = sum_w[15:0];
        end
      end
      SWAU_OP_MUL: begin
        res_lo = prod_w[15:0];
        res_hi = prod_w[31:16];
      end
      SWAU_OP_DIV: begin
        res_lo = quo_w[15:0];
        res_hi = rem_w[15:0];
      end
      default: begin
        res_lo = WORD_ZERO;
      end
    endcase
  end
endmodule : swau_calc

// ---- bench/swau_assertions.sv ----
// Port checker of the saturating word arithmetic unit
`timescale 1ns/10ps
module swau_chk
  import swau_pkg::*;
#(
  parameter int DEPTH = TBL_MAX
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              en_inv,
  input wire logic              en_add,
  input wire logic              en_sub,
  input wire logic              en_mul,
  input wire logic              en_div,
  input wire logic              err_clr,
  input wire logic              rd_en,
  input wire logic              wr_en,
  input wire logic              op_out,
  input wire logic              instruction_error_flag,
  input wire logic [15:0]       opnd_a,
  input wire logic [15:0]       opnd_b,
  input wire logic [15:0]       rd_data,
  input wire logic [15:0]       wr_data,
  input wire logic [ADDR_W-1:0] src_addr,
  input wire logic [ADDR_W-1:0] dst_addr,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [LEN_W-1:0]  tbl_len
);
  int          sa, sb, quo, rem;
  logic [16:0] add_s, sub_s;
  logic [31:0] prod;
  logic        any_en;

  // Clamp to the word range; bit 16 flags a clamp
  function automatic logic [16:0] sat(int v);
    return (v > 32767) ? {1'b1, SAT_POS} : (v < -32768) ? {1'b1, SAT_NEG} : {1'b0, v[15:0]};
  endfunction : sat

  // Reference results from the operands now on the inputs
  assign sa = int'($signed(opnd_a));
  assign sb = int'($signed(opnd_b));
  assign add_s = sat(sa + sb);
  assign sub_s = sat(sa - sb);
  assign prod = 32'(sa * sb);
  assign quo = (sb == 0) ? 0 : sa / sb;
  assign rem = (sb == 0) ? 0 : sa % sb;
  assign any_en = en_inv | en_add | en_sub | en_mul | en_div;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_add_result: assert property ($rose(en_add) |-> ##2 wr_en &&
    wr_addr == $past(dst_addr, 2) && {op_out, wr_data} == $past(add_s, 2))
    else $error("add wrong");
  a_sub_result: assert property ($rose(en_sub) |-> ##2 wr_en &&
    wr_addr == $past(dst_addr, 2) && {op_out, wr_data} == $past(sub_s, 2))
    else $error("sub wrong");
  a_mul_halves: assert property ($rose(en_mul) |-> ##2 wr_en &&
    wr_data == $past(prod[15:0], 2) ##1 wr_en && op_out && wr_data == $past(prod[31:16], 3)
    && wr_addr == $past(dst_addr, 3) + ADDR_ONE) else $error("mul wrong");
  a_div_result: assert property ($rose(en_div) && sb != 0 |-> ##2 wr_en &&
    wr_data == $past(quo[15:0], 2) ##1 wr_en && op_out && wr_data == $past(rem[15:0], 3))
    else $error("div wrong");
  a_div_zero: assert property ($rose(en_div) && sb == 0 |-> ##1
    (!wr_en && !op_out)[*3] ##0 instruction_error_flag) else $error("zero divisor wrong");
  a_flag_sticky: assert property (instruction_error_flag && !err_clr |=>
    instruction_error_flag) else $error("error flag dropped");
  a_flag_clear: assert property (err_clr && !en_div |=> !instruction_error_flag)
    else $error("error flag not cleared");
  a_quiet_idle: assert property (!any_en [*3] |-> !op_out && !wr_en && !rd_en)
    else $error("activity without enable");
  a_read_inv: assert property (rd_en |-> en_inv && 16'(rd_addr - src_addr) < tbl_len)
    else $error("read outside source table");

  c_inv: cover property ($rose(en_inv) ##[1:40] op_out);
  c_sat: cover property ($rose(en_add) ##2 op_out);
  c_err: cover property (instruction_error_flag && err_clr);
endmodule : swau_chk

bind swau_top swau_chk #(
  .DEPTH(DEPTH)
) u_chk (
  .sys_clk                (sys_clk),
  .rst_n                  (rst_n),
  .en_inv                 (en_inv),
  .en_add                 (en_add),
  .en_sub                 (en_sub),
  .en_mul                 (en_mul),
  .en_div                 (en_div),
  .err_clr                (err_clr),
  .rd_en                  (rd_en),
  .wr_en                  (wr_en),
  .op_out                 (op_out),
  .instruction_error_flag (instruction_error_flag),
  .opnd_a                 (opnd_a),
  .opnd_b                 (opnd_b),
  .rd_data                (rd_data),
  .wr_data                (wr_data),
  .src_addr               (src_addr),
  .dst_addr               (dst_addr),
  .rd_addr                (rd_addr),
  .wr_addr                (wr_addr),
  .tbl_len                (tbl_len)
);

// ---- bench/tb_top.sv ----
// Self-checking bench of the word arithmetic unit against a word-level model
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top
  import swau_pkg::*;
;
  logic              sys_clk = 0, rst_n = 0, err_clr = 0, ref_flag = 0;
  logic              rd_en, wr_en, op_out, instruction_error_flag;
  logic [4:0]        en_v = 0;
  logic [15:0]       opnd_a = 0, opnd_b = 0, rd_data = 0, wr_data;
  logic [ADDR_W-1:0] src_addr = 0, dst_addr = 0, rd_addr, wr_addr;
  logic [LEN_W-1:0]  tbl_len = 1;
  logic [15:0]       mem [64], ref_m [64];
  logic [15:0]       tmp [$];
  int                miscompares = 0, compares = 0, op;

  swau_top #(.DEPTH(8)) dut (.sys_clk, .rst_n, .en_inv(en_v[0]), .en_add(en_v[1]),
    .en_sub(en_v[2]), .en_mul(en_v[3]), .en_div(en_v[4]), .opnd_a, .opnd_b, .src_addr,
    .dst_addr, .tbl_len, .err_clr, .rd_data, .rd_en, .rd_addr, .wr_en, .wr_addr, .wr_data,
    .op_out, .instruction_error_flag);

  // Clock of 4 ns
  initial forever #2 sys_clk = ~sys_clk;

  // Register file: read data one cycle after the strobe, scrambled otherwise
  always @(posedge sys_clk) begin
    if (rd_en) rd_data <= #1 mem[rd_addr[5:0]];
    else rd_data <= #1 ~rd_data;
    if (wr_en) mem[wr_addr[5:0]] <= wr_data;
  end

  task automatic wrap_up;
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Model one instruction, run it on the unit, compare the whole register file
  task automatic run(int op, logic [15:0] a, b, int src, dst, len);
    int   sa, sb, v, lim;
    logic eo;
    sa = int'($signed(a));
    sb = int'($signed(b));
    eo = 1;
    case (op)
      0: begin
        tmp.delete();
        for (int k = 0; k < len; k++) tmp.push_back(~ref_m[src + k]);
        for (int k = 0; k < len; k++) ref_m[dst + k] = tmp.pop_front();
      end
      1, 2: begin
        v = (op == 1) ? sa + sb : sa - sb;
        eo = v > 32767 || v < -32768;
        ref_m[dst] = eo ? (v > 0 ? SAT_POS : SAT_NEG) : v[15:0];
      end
      3: begin
        v = sa * sb;
        ref_m[dst] = v[15:0];
        ref_m[dst + 1] = v[31:16];
      end
      default: if (sb == 0) begin
        eo = 0;
        ref_flag = 1;
      end else begin
        v = sa / sb;
        ref_m[dst] = v[15:0];
        v = sa % sb;
        ref_m[dst + 1] = v[15:0];
      end
    endcase
    @(posedge sys_clk) #1;
    {opnd_a, opnd_b, src_addr, dst_addr, tbl_len} = {a, b, 16'(src), 16'(dst), 11'(len)};
    en_v = 5'(1 << op);
    lim = eo ? 2 * len + 12 : 4;
    for (int k = 0; k < lim && op_out !== 1'b1; k++) @(posedge sys_clk) #1;
    `CHK(op_out, eo)
    if (eo && op_out !== 1'b1) wrap_up();
    en_v = 0;
    repeat (3) @(posedge sys_clk) #1;
    `CHK(op_out, 1'b0)
    for (int i = 0; i < 64; i++) `CHK(mem[i], ref_m[i])
    `CHK(instruction_error_flag, ref_flag)
  endtask : run

  // Pulse the error clear for one cycle
  task automatic clear;
    err_clr = 1;
    @(posedge sys_clk) #1;
    err_clr = 0;
    ref_flag = 0;
    `CHK(instruction_error_flag, 1'b0)
  endtask : clear

  // Directed cases, then a random mix
  initial begin
    void'($urandom(32'h0ad99f3f));
    for (int i = 0; i < 64; i++) mem[i] = 16'($urandom);
    ref_m = mem;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1;
    run(0, 0, 0, 0, 20, 5);
    run(0, 0, 0, 20, 22, 6);
    run(0, 0, 0, 30, 27, 8);
    run(0, 0, 0, 40, 41, 1);
    run(1, 16'h7fbc, 16'h03e8, 0, 50, 1);
    run(1, 16'h8000, 16'hffff, 0, 51, 1);
    run(2, 16'h86e8, 16'h09c4, 0, 52, 1);
    run(2, 16'h7fff, 16'hffff, 0, 53, 1);
    run(1, 16'h3039, 16'h03e8, 0, 54, 1);
    run(2, 16'h3a98, 16'h09c4, 0, 63, 1);
    run(3, 16'h8000, 16'h8000, 0, 55, 1);
    run(4, 16'h8000, 16'hffff, 0, 57, 1);
    run(4, 16'hf000, 16'h0007, 0, 59, 1);
    run(4, 16'h1234, 16'h0000, 0, 61, 1);
    run(1, 16'h0005, 16'h0006, 0, 62, 1);
    clear();
    for (int n = 0; n < 60; n++) begin
      op = $urandom % 5;
      run(op, 16'($urandom), ($urandom % 8 == 0) ? 16'h0 : 16'($urandom), $urandom % 56,
        $urandom % 56, 1 + $urandom % 8);
      if ($urandom % 4 == 0) clear();
    end
    wrap_up();
  end
endmodule : tb_top
